// ---- src/smam_mapper.sv ----
// Address mapper that turns user requests into bus transaction descriptors.
`timescale 1ns/1ps
module smam_mapper
	import smam_pkg::*;
(
	// System clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// User request port.
	input wire logic reqValid,
	input wire smam_req_t reqData,
	output logic reqReady,
	// User answer port.
	output logic rspValid,
	output logic rspErr,
	output logic [DATA_W-1:0] rspData,
	// Protocol table load port for non-linear targets.
	input wire logic mapWe,
	input wire logic [CMD_W-1:0] mapCmd,
	input wire smam_proto_t mapProto,
	// Link side, clocked by the link clock.
	input wire logic linkClk,
	output logic lnkValid,
	output smam_desc_t lnkDesc,
	input wire logic lnkDone,
	input wire logic [DATA_W-1:0] lnkRdata
);

	////////////////////////////////////////////////////////////////////////
	// Protocol table: one entry per command code.

	// Assigned protocol of each command of the non-linear target.
	smam_proto_t protoTab_r [TABLE_DEPTH];
	smam_proto_t protoTab_nxt [TABLE_DEPTH];

	genvar gi;
	generate
		for (gi = 0; gi < TABLE_DEPTH; gi++) begin : g_tab
			// Each entry loads only when its own command is addressed.
			always_comb begin
				protoTab_nxt[gi] = protoTab_r[gi];
				if (mapWe && mapCmd == CMD_W'(gi)) begin
					protoTab_nxt[gi] = mapProto;
				end
			end
			// Entries reset to byte, the narrowest data protocol.
			always_ff @(posedge mclk) begin
				if (!rst_n) begin
					protoTab_r[gi] <= PROTO_RST;
				end else begin
					protoTab_r[gi] <= protoTab_nxt[gi];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Request side state on the system clock.

	typedef enum logic [0:0] {
		ST_IDLE,
		ST_WAIT
	} smam_state_t;

	smam_state_t state_r, state_nxt;
	// Descriptor handed over; held stable while the link owns it.
	smam_desc_t desc_r, desc_nxt;
	// Word registers still to move for the current field.
	logic [3:0] wordsLeft_r, wordsLeft_nxt;
	logic reqTgl_r, reqTgl_nxt;
	logic ackSeen_r, ackSeen_nxt;
	logic reqReady_r, reqReady_nxt;
	logic rspValid_r, rspValid_nxt;
	logic rspErr_r, rspErr_nxt;
	logic [DATA_W-1:0] rspData_r, rspData_nxt;
	// Acknowledge toggle from the link domain, two-stage synchroniser.
	logic ackMeta_r, ackSync_r;
	logic lnkAckTgl_r;
	// Read data captured in the link domain, stable once ack is seen.
	logic [DATA_W-1:0] lnkRd_r;

	logic take;
	logic ackEdge;
	logic bad;
	smam_desc_t build;

	// Decode a request into its first descriptor and check it.
	always_comb begin
		take = reqValid && reqReady_r;
		ackEdge = ackSync_r != ackSeen_r;
		build = '0;
		bad = 1'b0;
		build.wdata = reqData.wdata;
		case (reqData.target)
			TGT_QUICK: begin
				// Only the address byte is sent; nothing follows it.
				build.addrByte = {reqData.slave, reqData.isRead}; // [RULE10] [RULE11] [RULE14]
				build.proto = PR_QUICK; // [RULE12]
				build.byteCount = LEN_QUICK;
				build.sendCmd = 1'b0;
			end
			TGT_LINEAR: begin
				// Upper seven bits pick the slave, lower eight the command.
				build.addrByte = {reqData.linAddr[LIN_W-1:CMD_W],
					reqData.isRead}; // [RULE5]
				build.cmd = reqData.linAddr[CMD_W-1:0];
				build.sendCmd = 1'b1;
				build.proto = reqData.proto; // [RULE7]
				bad = reqData.proto == PR_QUICK;
			end
			default: begin
				// Command must be used with its assigned protocol only.
				build.addrByte = {reqData.slave, reqData.isRead}; // [RULE1] [RULE2] [RULE3]
				build.cmd = reqData.cmd; // [RULE4]
				build.sendCmd = 1'b1;
				build.proto = reqData.proto;
				bad = reqData.proto != protoTab_r[reqData.cmd]; // [RULE8]
			end
		endcase
		case (build.proto)
			PR_BYTE: build.byteCount = LEN_BYTE;
			PR_WORD: build.byteCount = LEN_WORD; // [RULE6]
			PR_BLOCK: begin
				build.byteCount = reqData.blockLen;
				// A zero or oversize block cannot be sent in one go.
				if (reqData.blockLen == LEN_QUICK ||
					reqData.blockLen > LEN_BLOCK_MAX) begin // [RULE9]
					bad = 1'b1;
				end
			end
			default: build.byteCount = LEN_QUICK;
		endcase
	end

	// Next values of the request side.
	always_comb begin
		state_nxt = state_r;
		desc_nxt = desc_r;
		wordsLeft_nxt = wordsLeft_r;
		reqTgl_nxt = reqTgl_r;
		ackSeen_nxt = ackSeen_r;
		reqReady_nxt = reqReady_r;
		rspValid_nxt = 1'b0;
		rspErr_nxt = rspErr_r;
		rspData_nxt = rspData_r;
		case (state_r)
			ST_IDLE: begin
				if (take && bad) begin
					// Refused at once; the link never sees it.
					rspValid_nxt = 1'b1;
					rspErr_nxt = 1'b1;
					rspData_nxt = '0;
				end else if (take) begin
					desc_nxt = build;
					wordsLeft_nxt = (build.proto == PR_WORD &&
						reqData.wordRegs != 4'h0) ? reqData.wordRegs : 4'h1;
					reqTgl_nxt = !reqTgl_r;
					reqReady_nxt = 1'b0;
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (ackEdge) begin
					ackSeen_nxt = ackSync_r;
					if (wordsLeft_r > 4'h1) begin
						// Next word register of the same field.
						desc_nxt.cmd = desc_r.cmd + WORD_STEP; // [RULE15]
						wordsLeft_nxt = wordsLeft_r - 4'h1;
						reqTgl_nxt = !reqTgl_r;
					end else begin
						rspValid_nxt = 1'b1;
						rspErr_nxt = 1'b0;
						// A quick read has no data, so the answer is zero.
						rspData_nxt = (desc_r.proto == PR_QUICK) ?
							'0 : lnkRd_r; // [RULE13]
						reqReady_nxt = 1'b1;
						state_nxt = ST_IDLE;
					end
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// Registers of the request side; the ack synchroniser lives here too.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			desc_r <= '0;
			wordsLeft_r <= 4'h0;
			reqTgl_r <= 1'b0;
			ackSeen_r <= 1'b0;
			reqReady_r <= 1'b1;
			rspValid_r <= 1'b0;
			rspErr_r <= 1'b0;
			rspData_r <= '0;
			ackMeta_r <= 1'b0;
			ackSync_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			desc_r <= desc_nxt;
			wordsLeft_r <= wordsLeft_nxt;
			reqTgl_r <= reqTgl_nxt;
			ackSeen_r <= ackSeen_nxt;
			reqReady_r <= reqReady_nxt;
			rspValid_r <= rspValid_nxt;
			rspErr_r <= rspErr_nxt;
			rspData_r <= rspData_nxt;
			ackMeta_r <= lnkAckTgl_r;
			ackSync_r <= ackMeta_r;
		end
	end

	assign reqReady = reqReady_r;
	assign rspValid = rspValid_r;
	assign rspErr = rspErr_r;
	assign rspData = rspData_r;

	////////////////////////////////////////////////////////////////////////
	// Link side on the link clock.

	// Reset and request toggle are brought in through two flops each.
	logic lnkRstMeta_r, lnkRstN_r;
	logic reqMeta_r, reqSync_r;
	logic reqSeen_r, reqSeen_nxt;
	logic lnkAckTgl_nxt;
	logic lnkValid_r, lnkValid_nxt;
	smam_desc_t lnkDesc_r, lnkDesc_nxt;
	logic [DATA_W-1:0] lnkRd_nxt;

	// The descriptor is copied only after the toggle is synchronised, so
	// it has been stable for at least two link edges; no word crosses
	// while it is still changing.
	always_comb begin
		reqSeen_nxt = reqSeen_r;
		lnkAckTgl_nxt = lnkAckTgl_r;
		lnkValid_nxt = lnkValid_r;
		lnkDesc_nxt = lnkDesc_r;
		lnkRd_nxt = lnkRd_r;
		if (!lnkValid_r && reqSync_r != reqSeen_r) begin
			reqSeen_nxt = reqSync_r;
			lnkDesc_nxt = desc_r;
			lnkValid_nxt = 1'b1;
		end else if (lnkValid_r && lnkDone) begin
			lnkRd_nxt = lnkRdata;
			lnkValid_nxt = 1'b0;
			lnkAckTgl_nxt = !lnkAckTgl_r;
		end
	end

	// Registers of the link side.
	always_ff @(posedge linkClk) begin
		lnkRstMeta_r <= rst_n;
		lnkRstN_r <= lnkRstMeta_r;
		if (!lnkRstN_r) begin
			reqMeta_r <= 1'b0;
			reqSync_r <= 1'b0;
			reqSeen_r <= 1'b0;
			lnkAckTgl_r <= 1'b0;
			lnkValid_r <= 1'b0;
			lnkDesc_r <= '0;
			lnkRd_r <= '0;
		end else begin
			reqMeta_r <= reqTgl_r;
			reqSync_r <= reqMeta_r;
			reqSeen_r <= reqSeen_nxt;
			lnkAckTgl_r <= lnkAckTgl_nxt;
			lnkValid_r <= lnkValid_nxt;
			lnkDesc_r <= lnkDesc_nxt;
			lnkRd_r <= lnkRd_nxt;
		end
	end

	assign lnkValid = lnkValid_r;
	assign lnkDesc = lnkDesc_r;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	a_addr_byte: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2] [RULE3]
		take && !bad && reqData.target == TGT_NONLINEAR |=>
		desc_r.addrByte == {$past(reqData.slave), $past(reqData.isRead)})
		else $error("address byte not slave plus direction");
	a_linear_split: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE5]
		take && !bad && reqData.target == TGT_LINEAR |=>
		desc_r.addrByte[7:1] == $past(reqData.linAddr[14:8]) &&
		desc_r.cmd == $past(reqData.linAddr[7:0]))
		else $error("linear address split wrong");
	a_quick_empty: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE10]
		state_r == ST_WAIT && desc_r.proto == PR_QUICK |->
		!desc_r.sendCmd && desc_r.byteCount == 6'h00)
		else $error("quick transaction carries payload");
	a_quick_zero: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE13]
		state_r == ST_WAIT && ackEdge && desc_r.proto == PR_QUICK &&
		wordsLeft_r <= 4'h1 |=> rspValid_r && rspData_r == 16'h0000)
		else $error("quick read returned data");
	a_proto_refuse: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE8]
		take && reqData.target == TGT_NONLINEAR &&
		reqData.proto != protoTab_r[reqData.cmd] |=>
		rspValid_r && rspErr_r && state_r == ST_IDLE)
		else $error("protocol mismatch not refused");
	a_block_limit: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE9]
		state_r == ST_WAIT && desc_r.proto == PR_BLOCK |->
		desc_r.byteCount >= 6'h01 && desc_r.byteCount <= 6'h20)
		else $error("block length out of range");
	a_word_step: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE15]
		state_r == ST_WAIT && ackEdge && wordsLeft_r > 4'h1 |=>
		desc_r.cmd == $past(desc_r.cmd) + 8'h02 && state_r == ST_WAIT)
		else $error("word field did not step by two");
	a_word_len: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE6]
		state_r == ST_WAIT && desc_r.proto == PR_WORD |->
		desc_r.byteCount == 6'h02)
		else $error("word access not two bytes");
	a_quick_dir: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE12] [RULE14]
		take && reqData.target == TGT_QUICK |=>
		desc_r.proto == PR_QUICK && desc_r.addrByte[0] == $past(reqData.isRead))
		else $error("quick direction wrong");
	a_link_hold: assert property (@(posedge linkClk) disable iff (!lnkRstN_r)
		lnkValid_r && !lnkDone |=> lnkValid_r && $stable(lnkDesc_r))
		else $error("link descriptor changed while pending");

	c_quick_read: cover property (@(posedge mclk) disable iff (!rst_n)
		rspValid_r && !rspErr_r && desc_r.proto == PR_QUICK);
	c_refused: cover property (@(posedge mclk) disable iff (!rst_n)
		rspValid_r && rspErr_r);
	c_word_multi: cover property (@(posedge mclk) disable iff (!rst_n)
		state_r == ST_WAIT && ackEdge && wordsLeft_r > 4'h1);
	c_block: cover property (@(posedge mclk) disable iff (!rst_n)
		rspValid_r && desc_r.proto == PR_BLOCK);

endmodule

// ---- src/smam_pkg.sv ----
// Package of types and constants for the bus address mapper.
// Function
// [RULE1] Targets named by unshifted seven-bit slave address.
// [RULE2] Address byte is slave shifted up, flag low.
// [RULE3] Flag zero writes, one reads: 0x16/0x17.
// [RULE4] Eight-bit command code gives 256 registers.
// [RULE5] Linear address: slave high seven, command low.
// [RULE6] Linear word access covers command and next.
// [RULE7] Linear targets take byte, word or block.
// [RULE8] Non-linear commands use only their assigned protocol.
// [RULE9] Block payload at most thirty-two bytes.
// [RULE10] Quick sends address byte only, no data.
// [RULE11] Quick target has no command registers.
// [RULE12] Write gives quick write, read quick read.
// [RULE13] Quick read returns zero to the requester.
// [RULE14] Quick direction flag follows normal write/read convention.
// [RULE15] Wider word fields step command by two.
package smam_pkg;

	// Field widths of the addressing scheme.
	localparam int SLAVE_W = 7;
	localparam int CMD_W = 8;
	localparam int LIN_W = SLAVE_W + CMD_W;
	localparam int DATA_W = 16;
	localparam int CNT_W = 6;

	// Direction flag codes placed in bit 0 of the address byte.
	localparam logic DIR_WRITE = 1'h0;
	localparam logic DIR_READ = 1'h1;

	// Payload sizes in bytes for each protocol.
	localparam logic [CNT_W-1:0] LEN_QUICK = 6'h00;
	localparam logic [CNT_W-1:0] LEN_BYTE = 6'h01;
	localparam logic [CNT_W-1:0] LEN_WORD = 6'h02;
	localparam logic [CNT_W-1:0] LEN_BLOCK_MAX = 6'h20;

	// Command step between consecutive word registers of one field.
	localparam logic [CMD_W-1:0] WORD_STEP = 8'h02;

	// Number of entries in the command protocol table, one per code.
	localparam int TABLE_DEPTH = 256;

	// Wire protocol chosen for one transaction.
	typedef enum logic [1:0] {
		PR_QUICK,
		PR_BYTE,
		PR_WORD,
		PR_BLOCK
	} smam_proto_t;

	// Reset value of every table entry: byte, the narrowest data protocol.
	localparam smam_proto_t PROTO_RST = PR_BYTE;

	// How the target is addressed.
	typedef enum logic [1:0] {
		TGT_QUICK,
		TGT_LINEAR,
		TGT_NONLINEAR
	} smam_target_t;

	// A request from the user side.
	typedef struct packed {
		smam_target_t target;
		smam_proto_t proto;
		logic isRead;
		logic [SLAVE_W-1:0] slave;
		logic [CMD_W-1:0] cmd;
		logic [LIN_W-1:0] linAddr;
		logic [3:0] wordRegs;
		logic [CNT_W-1:0] blockLen;
		logic [DATA_W-1:0] wdata;
	} smam_req_t;

	// One transaction handed to the link engine.
	typedef struct packed {
		logic [7:0] addrByte;
		logic sendCmd;
		logic [CMD_W-1:0] cmd;
		smam_proto_t proto;
		logic [CNT_W-1:0] byteCount;
		logic [DATA_W-1:0] wdata;
	} smam_desc_t;

endpackage

// ---- test/smam_link_model.sv ----
// Behavioural link engine that answers mapper descriptors on the link clock.
`timescale 1ns/1ps
module smam_link_model
	import smam_pkg::*;
(
	// Link clock and system reset.
	input wire logic linkClk,
	input wire logic rst_n,
	// Descriptor handshake with the mapper.
	input wire logic lnkValid,
	input wire smam_desc_t lnkDesc,
	output logic lnkDone,
	output logic [DATA_W-1:0] lnkRdata,
	// Bench controls and transaction log.
	input wire logic [3:0] stall,
	output smam_desc_t lastDesc,
	output int txCount
);
	logic [3:0] waitCnt; // Cycles spent on the pending descriptor.

	////////////////////////////////////////////////////////////////////////
	// The data lines toggle outside the answer cycle, so stale data is
	// never mistaken for a fresh answer.
	always @(posedge linkClk) begin
		if (!rst_n) begin
			lnkDone <= 1'b0;
			waitCnt <= 4'h0;
			txCount <= 0;
			lastDesc <= '0;
			lnkRdata <= 16'h5A5A;
		end else if (lnkDone) begin
			// The answered descriptor is logged for the bench to inspect.
			lnkRdata <= ~lnkRdata;
			lnkDone <= 1'b0;
			waitCnt <= 4'h0;
			lastDesc <= lnkDesc;
			txCount <= txCount + 1;
		end else if (lnkValid && waitCnt == stall) begin
			// Data echoes address byte and command, so it can be predicted.
			lnkDone <= 1'b1;
			lnkRdata <= {lnkDesc.addrByte, lnkDesc.cmd};
		end else begin
			lnkRdata <= ~lnkRdata;
			if (lnkValid) begin
				waitCnt <= waitCnt + 4'h1;
			end
		end
	end
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the bus address mapper.
`timescale 1ns/1ps
module tb
	import smam_pkg::*;
;
	logic mclk = 1'b0, linkClk = 1'b0, rst_n = 1'b0;
	logic reqValid = 1'b0, mapWe = 1'b0;
	smam_req_t reqData = '0;
	logic [CMD_W-1:0] mapCmd = 8'h00;
	smam_proto_t mapProto = PR_BYTE;
	logic reqReady, rspValid, rspErr, lnkValid, lnkDone;
	logic [DATA_W-1:0] rspData, lnkRdata;
	smam_desc_t lnkDesc, lastDesc;
	logic [3:0] stall = 4'h0;
	int txCount, failCount = 0, checks = 0;

	always #5 mclk = ~mclk;
	initial #37 forever #80 linkClk = ~linkClk;

	smam_mapper dut (.mclk(mclk), .rst_n(rst_n), .reqValid(reqValid),
		.reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
		.rspErr(rspErr), .rspData(rspData), .mapWe(mapWe), .mapCmd(mapCmd),
		.mapProto(mapProto), .linkClk(linkClk), .lnkValid(lnkValid),
		.lnkDesc(lnkDesc), .lnkDone(lnkDone), .lnkRdata(lnkRdata));
	smam_link_model far (.linkClk(linkClk), .rst_n(rst_n),
		.lnkValid(lnkValid), .lnkDesc(lnkDesc), .lnkDone(lnkDone),
		.lnkRdata(lnkRdata), .stall(stall), .lastDesc(lastDesc),
		.txCount(txCount));

	////////////////////////////////////////////////////////////////////////
	// Comparison and closing tasks.
	task automatic chkWord(string what, logic [15:0] exp, logic [15:0] got);
		checks++;
		if (got !== exp) begin
			failCount++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", checks, failCount);
		if (failCount == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	function automatic smam_req_t mk(smam_target_t tg, smam_proto_t p,
			logic rd, logic [6:0] s, logic [7:0] c, logic [14:0] la,
			logic [3:0] w, logic [5:0] n);
		return '{tg, p, rd, s, c, la, w, n, 16'hC3A5};
	endfunction

	// Loads one protocol table entry; it is usable the next cycle.
	task automatic loadMap(logic [7:0] c, smam_proto_t p);
		mapCmd = c;
		mapProto = p;
		mapWe = 1'b1;
		@(posedge mclk);
		#1 mapWe = 1'b0;
	endtask

	// One request: held for one clock edge after reqReady is checked high, then the answer is awaited, bounded.
	task automatic doReq(smam_req_t r, logic e, int nTx, logic [7:0] a,
			logic [7:0] c, logic [5:0] cnt);
		int n0;
		int t;
		n0 = txCount;
		reqData = r;
		reqValid = 1'b1;
		chkWord("reqReady idle", 16'h1, {15'h0, reqReady});
		@(posedge mclk);
		#1 reqValid = 1'b0;
		t = 0;
		while (rspValid !== 1'b1 && t < 3000) begin
			@(posedge mclk);
			#1 t++;
		end
		chkWord("rspValid", 16'h1, {15'h0, rspValid});
		chkWord("rspErr", {15'h0, e}, {15'h0, rspErr});
		chkWord("reqReady back", 16'h1, {15'h0, reqReady});
		chkWord("link count", nTx[15:0], 16'(txCount - n0));
		if (r.isRead || e)
			chkWord("rspData",
				(e || r.proto == PR_QUICK) ? 16'h0 : {a, c}, rspData);
		if (nTx > 0) begin
			chkWord("addrByte", {8'h0, a},
				{8'h0, lastDesc.addrByte});
			chkWord("cmd", {8'h0, c}, {8'h0, lastDesc.cmd});
			chkWord("byteCount", {10'h0, cnt},
				{10'h0, lastDesc.byteCount});
			chkWord("sendCmd", {15'h0, r.proto != PR_QUICK},
				{15'h0, lastDesc.sendCmd});
			// The protocol handed to the link is the one requested.
			chkWord("proto", {14'h0, r.proto},
				{14'h0, lastDesc.proto});
			// Write data passes through untouched.
			chkWord("wdata", 16'hC3A5, lastDesc.wdata);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic tLinear();
		stall = 4'h0;
		doReq(mk(TGT_LINEAR, PR_BYTE, 1, 0, 0, 15'h4000, 0, 0), 0, 1, 8'h81,
			8'h00, 6'h01);
		doReq(mk(TGT_LINEAR, PR_WORD, 0, 0, 0, 15'h40FE, 0, 0), 0, 1, 8'h80,
			8'hFE, 6'h02);
		doReq(mk(TGT_LINEAR, PR_BLOCK, 1, 0, 0, 15'h1234, 0, 32), 0, 1,
			8'h25, 8'h34, 6'h20);
		doReq(mk(TGT_LINEAR, PR_QUICK, 1, 0, 0, 15'h1234, 0, 0), 1, 0, 0, 0,
			0);
	endtask

	task automatic tNonLinear();
		stall = 4'h5;
		loadMap(8'h00, PR_WORD);
		doReq(mk(TGT_NONLINEAR, PR_WORD, 0, 7'h0B, 0, 0, 0, 0), 0, 1, 8'h16,
			8'h00, 6'h02);
		doReq(mk(TGT_NONLINEAR, PR_WORD, 1, 7'h0B, 0, 0, 0, 0), 0, 1, 8'h17,
			8'h00, 6'h02);
		doReq(mk(TGT_NONLINEAR, PR_BYTE, 1, 7'h0B, 0, 0, 0, 0), 1, 0, 0, 0,
			0);
		loadMap(8'h20, PR_BLOCK);
		doReq(mk(TGT_NONLINEAR, PR_BLOCK, 1, 7'h0B, 8'h20, 0, 0, 33), 1, 0,
			0, 0, 0);
		doReq(mk(TGT_NONLINEAR, PR_BLOCK, 1, 7'h0B, 8'h20, 0, 0, 0), 1, 0,
			0, 0, 0);
		doReq(mk(TGT_NONLINEAR, PR_BLOCK, 1, 7'h0B, 8'h20, 0, 0, 32), 0, 1,
			8'h17, 8'h20, 6'h20);
		doReq(mk(TGT_NONLINEAR, PR_BYTE, 1, 7'h0B, 8'h21, 0, 0, 0), 0, 1,
			8'h17, 8'h21, 6'h01);
		loadMap(8'h04, PR_WORD);
		doReq(mk(TGT_NONLINEAR, PR_WORD, 1, 7'h0B, 8'h04, 0, 3, 0), 0, 3,
			8'h17, 8'h08, 6'h02);
	endtask

	task automatic tQuick();
		stall = 4'h2;
		doReq(mk(TGT_QUICK, PR_QUICK, 0, 7'h61, 0, 0, 0, 0), 0, 1, 8'hC2,
			8'h00, 6'h00);
		doReq(mk(TGT_QUICK, PR_QUICK, 1, 7'h61, 0, 0, 0, 0), 0, 1, 8'hC3,
			8'h00, 6'h00);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Reset is held long enough for the link domain's reset flops too.
	initial begin
		repeat (50) @(posedge mclk);
		#1 rst_n = 1'b1;
		repeat (60) @(posedge mclk);
		#1 tLinear();
		tNonLinear();
		tQuick();
		giveVerdict();
	end

	// Watchdog: the sequence needs well under a tenth of this span.
	initial begin
		#400000;
		failCount++;
		giveVerdict();
	end
endmodule
